/* File: src/acr_regs_top.v */
// Acquisition control register bank with sample sequencer and output regs
// How it works
// - Rate field resets to 000; codes 001..111 select 1 to 200 Hz.
// - Rate 000 is power-down; settings kept, outputs hold last sample.
// - Register port keeps working in power-down.
// - Single-acquisition write starts one conversion, only while rate is 000.
// - Finished single acquisition updates outputs and self-clears the bit.
// - Nonzero rate runs conversions repeatedly at the selected rate.
// - Rate codes 110 and 111 force low-noise mode off.
// - Bandwidth: filter off OUTPUT_RATE_SEL/2, config 0 OUTPUT_RATE_SEL/9, config 1 OUTPUT_RATE_SEL/20.
// - Pressure filter acts only in continuous mode; enable resets to 0.
// - Block update holds outputs until all three pressure bytes read.
// - Wire mode bit: 0 four-wire SPI, 1 three-wire; resets to 0.
// - Reboot bit reloads trimming from nonvolatile memory.
// - Interrupt polarity: 0 active high, 1 active low; resets to 0.
// - Auto-increment resets to one; enables address advance per byte.
// - Software reset bit performs a reset then clears itself.
// - Low-noise bit: 0 low current, 1 low noise, below 100 Hz only.
// - Reboot bit cleared by hardware when reload finishes.
// - Interrupt drive: 0 push-pull, 1 open-drain.
// - Software reset returns control registers to defaults first; pressure and temperature outputs keep their values.
`include "acr_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module acr_regs_top #(
    parameter [7:0]  IDENT_CODE = 8'h5a,
    parameter [25:0] PER_1HZ    = `ACR_PER_1HZ_US * `ACR_CLK_MHZ,
    parameter [25:0] PER_10HZ   = `ACR_PER_10HZ_US * `ACR_CLK_MHZ,
    parameter [25:0] PER_25HZ   = `ACR_PER_25HZ_US * `ACR_CLK_MHZ,
    parameter [25:0] PER_50HZ   = `ACR_PER_50HZ_US * `ACR_CLK_MHZ,
    parameter [25:0] PER_75HZ   = `ACR_PER_75HZ_US * `ACR_CLK_MHZ,
    parameter [25:0] PER_100HZ  = `ACR_PER_100HZ_US * `ACR_CLK_MHZ,
    parameter [25:0] PER_200HZ  = `ACR_PER_200HZ_US * `ACR_CLK_MHZ
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         conv_start,
    input  wire        conv_done,
    input  wire [23:0] conv_press,
    input  wire [15:0] conv_temp,
    output reg         trim_reload,
    input  wire        trim_done,
    input  wire        irq_level,
    output reg         irq_pad_out,
    output reg         irq_pad_oe,
    output wire        power_down,
    output wire        low_noise_active,
    output wire        filter_active,
    output wire [1:0]  bandwidth_sel,
    output wire        spi_three_wire,
    output wire        addr_auto_inc
);
    ////////////////////////////////////////////////////////////////////////
    reg  [7:0]  acq_ctrl_reg;
    reg  [7:0]  sys_cfg_reg;
    reg         one_shot_reg;
    reg         reboot_reg;
    reg         soft_rst_reg;
    reg         conv_busy_reg;
    reg  [25:0] tick_cnt_reg;
    reg  [23:0] press_out_reg;
    reg  [15:0] temp_out_reg;
    reg  [23:0] filt_reg;
    reg         filt_valid_reg;
    reg  [23:0] pend_press_reg;
    reg  [15:0] pend_temp_reg;
    reg         pend_reg;
    reg         lock_reg;
    reg  [2:0]  read_mask_reg;
    reg  [25:0] period;
    reg  [23:0] press_new;
    reg  [24:0] filt_diff;
    wire [2:0]  rate_sel = acq_ctrl_reg[`ACR_RATE_MSB:`ACR_RATE_LSB];
    wire        wr_acq   = reg_wr && reg_addr == `ACR_ADDR_ACQ_CTRL;
    wire        wr_sys   = reg_wr && reg_addr == `ACR_ADDR_SYS_CTRL;
    wire        tick     = !power_down && tick_cnt_reg == 26'h0000000;
    wire [2:0]  rd_hit   = {reg_rd && reg_addr == `ACR_ADDR_PRESS_H,
                            reg_rd && reg_addr == `ACR_ADDR_PRESS_L,
                            reg_rd && reg_addr == `ACR_ADDR_PRESS_XL};
    wire        all_read = &(read_mask_reg | rd_hit);
    wire        shot_go  = wr_sys && reg_wdata[`ACR_ONE_SHOT_BIT] &&
                           power_down && !one_shot_reg;

    assign power_down       = rate_sel == `ACR_RATE_OFF;
    assign low_noise_active = sys_cfg_reg[`ACR_LOW_NOISE_BIT] &&
                              rate_sel < `ACR_RATE_100HZ;
    assign filter_active    = acq_ctrl_reg[`ACR_FILT_EN_BIT] && !power_down;
    assign bandwidth_sel    = {filter_active,
                               filter_active &
                               acq_ctrl_reg[`ACR_FILT_CFG_BIT]};
    assign spi_three_wire   = acq_ctrl_reg[`ACR_WIRE_MODE_BIT];
    assign addr_auto_inc    = sys_cfg_reg[`ACR_AUTO_INC_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Rate period lookup
    always @* begin
        case (rate_sel)
            3'h1:    period = PER_1HZ;
            3'h2:    period = PER_10HZ;
            3'h3:    period = PER_25HZ;
            3'h4:    period = PER_50HZ;
            3'h5:    period = PER_75HZ;
            3'h6:    period = PER_100HZ;
            3'h7:    period = PER_200HZ;
            default: period = 26'h0000001;
        endcase
    end

    // Shift IIR; shifts 2 and 3 stand in for the OUTPUT_RATE_SEL/9 and OUTPUT_RATE_SEL/20 poles
    always @* begin
        filt_diff = {conv_press[23], conv_press} - {filt_reg[23], filt_reg};
        press_new = conv_press;
        if (filter_active && filt_valid_reg) begin
            if (acq_ctrl_reg[`ACR_FILT_CFG_BIT])
                press_new = filt_reg + {{3{filt_diff[24]}}, filt_diff[23:3]};
            else
                press_new = filt_reg + {{2{filt_diff[24]}}, filt_diff[23:2]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acq_ctrl_reg   <= `ACR_ACQ_CTRL_RST;
            sys_cfg_reg    <= `ACR_SYS_CTRL_RST;
            one_shot_reg   <= 1'b0;
            reboot_reg     <= 1'b0;
            soft_rst_reg   <= 1'b0;
            conv_busy_reg  <= 1'b0;
            conv_start     <= 1'b0;
            trim_reload    <= 1'b0;
            tick_cnt_reg   <= 26'h0000000;
            press_out_reg  <= 24'h000000;
            temp_out_reg   <= 16'h0000;
            filt_reg       <= 24'h000000;
            filt_valid_reg <= 1'b0;
            pend_press_reg <= 24'h000000;
            pend_temp_reg  <= 16'h0000;
            pend_reg       <= 1'b0;
            lock_reg       <= 1'b0;
            read_mask_reg  <= 3'h0;
        end else if (soft_rst_reg) begin
            acq_ctrl_reg   <= `ACR_ACQ_CTRL_RST;
            sys_cfg_reg    <= `ACR_SYS_CTRL_RST;
            one_shot_reg   <= 1'b0;
            reboot_reg     <= 1'b0;
            soft_rst_reg   <= 1'b0;
            conv_busy_reg  <= 1'b0;
            conv_start     <= 1'b0;
            trim_reload    <= 1'b0;
            tick_cnt_reg   <= 26'h0000000;
            filt_valid_reg <= 1'b0;
            pend_reg       <= 1'b0;
            lock_reg       <= 1'b0;
            read_mask_reg  <= 3'h0;
        end else begin
            conv_start  <= 1'b0;
            trim_reload <= 1'b0;
            if (wr_acq)
                acq_ctrl_reg <= {1'b0, reg_wdata[6:0]};
            if (wr_sys) begin
                sys_cfg_reg <= {1'b0, reg_wdata[`ACR_IRQ_POL_BIT],
                                reg_wdata[`ACR_IRQ_DRV_BIT],
                                reg_wdata[`ACR_AUTO_INC_BIT], 2'b00,
                                reg_wdata[`ACR_LOW_NOISE_BIT], 1'b0};
                soft_rst_reg <= reg_wdata[`ACR_SOFT_RST_BIT];
            end
            if (wr_sys && reg_wdata[`ACR_REBOOT_BIT] && !reboot_reg) begin
                reboot_reg  <= 1'b1;
                trim_reload <= 1'b1;
            end else if (trim_done) begin
                reboot_reg <= 1'b0;
            end
            if (power_down || tick)
                tick_cnt_reg <= period - 26'h0000001;
            else
                tick_cnt_reg <= tick_cnt_reg - 26'h0000001;
            if (shot_go) begin
                one_shot_reg  <= 1'b1;
                conv_start    <= 1'b1;
                conv_busy_reg <= 1'b1;
            end else if (tick && !conv_busy_reg) begin
                conv_start    <= 1'b1;
                conv_busy_reg <= 1'b1;
            end else if (conv_done) begin
                conv_busy_reg <= 1'b0;
                one_shot_reg  <= 1'b0;
            end
            // Filter state loads on every conversion; marked valid only in continuous mode
            if (conv_done) begin
                filt_reg       <= press_new;
                filt_valid_reg <= filter_active;
            end else if (!filter_active) begin
                filt_valid_reg <= 1'b0;
            end
            if (lock_reg)
                read_mask_reg <= all_read ? 3'h0 : read_mask_reg | rd_hit;
            if (conv_done && (lock_reg && !all_read)) begin
                pend_press_reg <= press_new;
                pend_temp_reg  <= conv_temp;
                pend_reg       <= 1'b1;
            end else if (conv_done) begin
                press_out_reg <= press_new;
                temp_out_reg  <= conv_temp;
                pend_reg      <= 1'b0;
                lock_reg      <= acq_ctrl_reg[`ACR_BLOCK_UPD_BIT];
            end else if (pend_reg && (!lock_reg || all_read)) begin
                press_out_reg <= pend_press_reg;
                temp_out_reg  <= pend_temp_reg;
                pend_reg      <= 1'b0;
                lock_reg      <= acq_ctrl_reg[`ACR_BLOCK_UPD_BIT];
            end else if (lock_reg && (all_read ||
                         !acq_ctrl_reg[`ACR_BLOCK_UPD_BIT])) begin
                lock_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data; unmapped addresses read zero
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACR_ADDR_IDENTITY: reg_rdata <= IDENT_CODE;
                `ACR_ADDR_ACQ_CTRL: reg_rdata <= acq_ctrl_reg;
                `ACR_ADDR_SYS_CTRL: reg_rdata <= sys_cfg_reg |
                    {reboot_reg, 4'h0, soft_rst_reg, 1'b0, one_shot_reg};
                `ACR_ADDR_PRESS_XL: reg_rdata <= press_out_reg[7:0];
                `ACR_ADDR_PRESS_L:  reg_rdata <= press_out_reg[15:8];
                `ACR_ADDR_PRESS_H:  reg_rdata <= press_out_reg[23:16];
                `ACR_ADDR_TEMP_L:   reg_rdata <= temp_out_reg[7:0];
                `ACR_ADDR_TEMP_H:   reg_rdata <= temp_out_reg[15:8];
                default:            reg_rdata <= 8'h00;
            endcase
        end
    end

    // Pad registered so polarity and drive changes never glitch it
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_pad_out <= 1'b0;
            irq_pad_oe  <= 1'b1;
        end else if (!sys_cfg_reg[`ACR_IRQ_DRV_BIT]) begin
            irq_pad_out <= irq_level ^ sys_cfg_reg[`ACR_IRQ_POL_BIT];
            irq_pad_oe  <= 1'b1;
        end else begin
            irq_pad_out <= 1'b0;
            irq_pad_oe  <= ~(irq_level ^ sys_cfg_reg[`ACR_IRQ_POL_BIT]);
        end
    end
endmodule
`default_nettype wire

/* File: inc/acr_regs.vh */
// Register map, field positions, reset values and timing counts
`ifndef ACR_REGS_VH
`define ACR_REGS_VH
`define ACR_ADDR_IDENTITY   8'h0f
`define ACR_ADDR_ACQ_CTRL   8'h10
`define ACR_ADDR_SYS_CTRL   8'h11
`define ACR_ADDR_PRESS_XL   8'h28
`define ACR_ADDR_PRESS_L    8'h29
`define ACR_ADDR_PRESS_H    8'h2a
`define ACR_ADDR_TEMP_L     8'h2b
`define ACR_ADDR_TEMP_H     8'h2c
// Acquisition control fields
`define ACR_RATE_MSB        6
`define ACR_RATE_LSB        4
`define ACR_FILT_EN_BIT     3
`define ACR_FILT_CFG_BIT    2
`define ACR_BLOCK_UPD_BIT   1
`define ACR_WIRE_MODE_BIT   0
// System control fields
`define ACR_REBOOT_BIT      7
`define ACR_IRQ_POL_BIT     6
`define ACR_IRQ_DRV_BIT     5
`define ACR_AUTO_INC_BIT    4
`define ACR_SOFT_RST_BIT    2
`define ACR_LOW_NOISE_BIT   1
`define ACR_ONE_SHOT_BIT    0
`define ACR_ACQ_CTRL_RST    8'h00
`define ACR_SYS_CTRL_RST    8'h10
// Rate codes
`define ACR_RATE_OFF        3'h0
`define ACR_RATE_100HZ      3'h6
// Clock frequency in MHz and sample periods in microseconds
`define ACR_CLK_MHZ         50
`define ACR_PER_1HZ_US      1000000
`define ACR_PER_10HZ_US     100000
`define ACR_PER_25HZ_US     40000
`define ACR_PER_50HZ_US     20000
`define ACR_PER_75HZ_US     13333
`define ACR_PER_100HZ_US    10000
`define ACR_PER_200HZ_US    5000
`endif

/* File: bench/acr_regs_monitor.sv */
// Port assertions for the acquisition control register bank
`timescale 1ns/1ps
`default_nettype none
module acr_regs_mon #(parameter [7:0] IDENT_CODE = 8'h5a) (
    input wire       core_clk,
    input wire       rst,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       trim_reload,
    input wire       irq_level,
    input wire       irq_pad_out,
    input wire       irq_pad_oe,
    input wire       power_down,
    input wire       low_noise_active,
    input wire       filter_active,
    input wire [1:0] bandwidth_sel,
    input wire       spi_three_wire,
    input wire       addr_auto_inc
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire acq_w = reg_wr && reg_addr == 8'h10;
    wire sys_any = reg_wr && reg_addr == 8'h11;
    wire sys_w = sys_any && !reg_wdata[2];
    sequence s_srst; sys_any && reg_wdata[2]; endsequence
    sequence s_irq_cfg; sys_w ##1 !sys_any; endsequence
    a_pd_follows:
    assert property (acq_w |=> power_down == ($past(reg_wdata[6:4]) == 3'h0))
        else $error("power-down level wrong after rate write");
    a_fast_noise:
    assert property (acq_w && reg_wdata[6:5] == 2'b11 |=> !low_noise_active)
        else $error("low noise left on at fast rate");
    a_filt_cont:
    assert property (filter_active |-> !power_down)
        else $error("filter active in power-down");
    a_bw_sel:
    assert property (acq_w |=> bandwidth_sel ==
        {$past(reg_wdata[3] && reg_wdata[6:4] != 3'h0),
         $past(reg_wdata[3] && reg_wdata[2] && reg_wdata[6:4] != 3'h0)})
        else $error("bandwidth select wrong");
    a_wire_mode:
    assert property (acq_w |=> spi_three_wire == $past(reg_wdata[0]))
        else $error("wire mode wrong");
    a_auto_inc:
    assert property (sys_w |=> addr_auto_inc == $past(reg_wdata[4]))
        else $error("auto increment wrong");
    a_ident_ro:
    assert property (reg_rd && reg_addr == 8'h0f |=> reg_rdata == IDENT_CODE)
        else $error("identity read wrong");
    a_irq_pad:
    assert property (s_irq_cfg |=> ($past(reg_wdata[5], 2) ?
        (!irq_pad_out && irq_pad_oe == !($past(irq_level) ^ $past(reg_wdata[6], 2)))
        : (irq_pad_oe && irq_pad_out == ($past(irq_level) ^ $past(reg_wdata[6], 2)))))
        else $error("interrupt pad drive wrong");
    a_srst_dflt:
    assert property (s_srst ##1 !reg_wr |=> power_down && addr_auto_inc
        && !spi_three_wire && bandwidth_sel == 2'b00)
        else $error("soft reset left controls set");
    a_boot_start:
    assert property (trim_reload |-> $past(sys_any && reg_wdata[7]))
        else $error("trim reload without reboot write");
endmodule
bind acr_regs_top acr_regs_mon #(.IDENT_CODE(IDENT_CODE)) acr_regs_mon_i (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .trim_reload(trim_reload), .irq_level(irq_level),
    .irq_pad_out(irq_pad_out), .irq_pad_oe(irq_pad_oe),
    .power_down(power_down), .low_noise_active(low_noise_active),
    .filter_active(filter_active), .bandwidth_sel(bandwidth_sel),
    .spi_three_wire(spi_three_wire), .addr_auto_inc(addr_auto_inc));
`default_nettype wire

/* File: bench/acr_conv_model.sv */
// Stand-in for the converter and the trimming memory
`timescale 1ns/1ps
`default_nettype none
module acr_conv_model (
    input  wire         core_clk,
    input  wire         rst,
    input  wire         conv_start,
    input  wire         trim_reload,
    input  wire  [7:0]  lat,
    output logic        conv_done,
    output wire  [23:0] conv_press,
    output wire  [15:0] conv_temp,
    output logic        trim_done
);
    logic [7:0] idx;
    logic [7:0] c_cnt;
    logic [7:0] t_cnt;
    wire [23:0] p = {idx, ~idx, idx ^ 8'h3c};
    // Results invert outside the done cycle so stale data never matches
    assign conv_press = conv_done ? p : ~p;
    assign conv_temp = conv_done ? {idx, ~idx} : {~idx, idx};
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx <= 8'h00;
            c_cnt <= 8'h00;
            t_cnt <= 8'h00;
            conv_done <= 1'b0;
            trim_done <= 1'b0;
        end else begin
            conv_done <= c_cnt == 8'h01;
            trim_done <= t_cnt == 8'h01;
            if (conv_done)
                idx <= idx + 8'h01;
            c_cnt <= conv_start ? lat : c_cnt - 8'(c_cnt != 8'h00);
            t_cnt <= trim_reload ? lat : t_cnt - 8'(t_cnt != 8'h00);
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the acquisition control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq_level = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, lat = 8'd3;
    wire [7:0] reg_rdata;
    wire [23:0] conv_press;
    wire [15:0] conv_temp;
    wire [1:0] bandwidth_sel;
    wire conv_start, conv_done, trim_reload, trim_done, irq_pad_out, irq_pad_oe;
    wire power_down, low_noise_active, filter_active, spi_three_wire;
    wire addr_auto_inc;
    int n_mismatch = 0, check_count = 0, n_done = 0, waited = 0;
    logic [7:0] exp_q[$];
    logic rd_seen = 0;
    always #10 core_clk = ~core_clk;
    acr_regs_top #(.PER_200HZ(26'd60)) acr_regs_top_i (
        .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_start(conv_start), .conv_done(conv_done),
        .conv_press(conv_press), .conv_temp(conv_temp),
        .trim_reload(trim_reload), .trim_done(trim_done),
        .irq_level(irq_level), .irq_pad_out(irq_pad_out),
        .irq_pad_oe(irq_pad_oe), .power_down(power_down),
        .low_noise_active(low_noise_active), .filter_active(filter_active),
        .bandwidth_sel(bandwidth_sel), .spi_three_wire(spi_three_wire),
        .addr_auto_inc(addr_auto_inc));
    acr_conv_model acr_conv_model_i (
        .core_clk(core_clk), .rst(rst), .conv_start(conv_start),
        .trim_reload(trim_reload), .lat(lat), .conv_done(conv_done),
        .conv_press(conv_press), .conv_temp(conv_temp),
        .trim_done(trim_done));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd = 1;
        reg_addr = a;
        exp_q.push_back(exp);
        @(negedge core_clk);
        reg_rd = 0;
        @(negedge core_clk);
    endtask
    task automatic rd_press(input logic [7:0] k);
        rd(8'h28, k ^ 8'h3c);
        rd(8'h29, ~k);
        rd(8'h2a, k);
    endtask
    // Bounded wait on a converter or trim completion pulse
    task automatic wait_ev(input bit trim);
        for (waited = 0; waited < 600; waited++) begin
            // Poll at the falling edge so the pulse is settled
            @(negedge core_clk);
            if ((trim ? trim_done : conv_done) === 1'b1)
                break;
        end
        if (waited == 600) begin
            n_mismatch++;
            finish_test();
        end
        @(negedge core_clk);
    endtask
    // Read data lands one edge after the strobe
    always @(posedge core_clk) rd_seen <= reg_rd;
    always @(posedge core_clk) n_done <= n_done + int'(conv_done === 1'b1);
    always @(negedge core_clk)
        if (rd_seen)
            check(reg_rdata, exp_q.pop_front());
    always @(negedge core_clk) irq_level <= 1'($urandom);
    initial begin
        logic [7:0] d, k;
        int r;
        void'($urandom(32'hd111d8c3));
        repeat (4) @(negedge core_clk);
        rst = 0;
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h10);
        wr(8'h0f, 8'ha5);
        rd(8'h0f, 8'h5a);
        rd(8'h20, 8'h00);
        check(8'(power_down), 8'h01);
        $display("reset values test done");
        wr(8'h11, 8'h12);
        for (r = 1; r < 8; r++) begin
            d = {1'b0, r[2:0], 4'($urandom)};
            wr(8'h10, d);
            rd(8'h10, d);
            check(8'(low_noise_active), 8'(r < 6));
            check(8'(bandwidth_sel), {6'h0, d[3], d[3] & d[2]});
            check(8'(filter_active), 8'(d[3]));
            check(8'(spi_three_wire), 8'(d[0]));
        end
        wr(8'h10, 8'h08);
        check(8'(filter_active), 8'h00);
        $display("rate field test done");
        wr(8'h11, 8'h10);
        lat = 8'd20;
        wr(8'h11, 8'h11);
        rd(8'h11, 8'h11);
        wait_ev(0);
        rd(8'h11, 8'h10);
        k = 8'(n_done - 1);
        rd_press(k);
        repeat (50) @(negedge core_clk);
        rd_press(k);
        $display("one-shot test done");
        lat = 8'd2;
        wr(8'h10, 8'h72);
        wait_ev(0);
        k = 8'(n_done - 1);
        wr(8'h11, 8'h11);
        rd(8'h11, 8'h10);
        wait_ev(0);
        wait_ev(0);
        // Period of 60 less the two polling edges lost around the pulse
        check(8'(waited), 8'd58);
        wr(8'h10, 8'h02);
        rd_press(k);
        rd_press(8'(n_done - 1));
        $display("continuous test done");
        for (r = 0; r < 16; r++) begin
            if (r % 4 == 0)
                wr(8'h11, {1'b0, r[3:2], 5'h10});
            @(posedge core_clk);
            d[0] = irq_level ^ r[3];
            @(negedge core_clk);
            check(8'({irq_pad_oe, irq_pad_out}),
                r[2] ? {6'h0, ~d[0], 1'b0} : {6'h0, 1'b1, d[0]});
        end
        $display("interrupt pad test done");
        lat = 8'd30;
        wr(8'h11, 8'h90);
        rd(8'h11, 8'h90);
        wait_ev(1);
        rd(8'h11, 8'h10);
        wr(8'h10, 8'h5b);
        wr(8'h11, 8'h06);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h10);
        rd(8'h2a, 8'(n_done - 1));
        $display("reboot and soft reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
